// ===== pkg/aatc_map.vh
// Register offsets, field positions, reset values and timing counts
// Assumes a 125 MHz system clock and a 16-bit register port
`ifndef AATC_MAP_VH
`define AATC_MAP_VH

// Register indexes on the plain register port
`define AATC_REG_CTRL 3'h0
`define AATC_REG_DIVISOR 3'h1
`define AATC_REG_PRE_COUNT 3'h2
`define AATC_REG_TOTAL_COUNT 3'h3
`define AATC_REG_THRESHOLD 3'h4
`define AATC_REG_STATUS 3'h5
`define AATC_REG_SW_TRIGGER 3'h6
`define AATC_REG_STORED 3'h7

// Control register fields
`define AATC_CTRL_MODE 0
`define AATC_CTRL_CLK_SRC 1
`define AATC_CTRL_TRIG_SRC_LO 2
`define AATC_CTRL_TRIG_SRC_HI 3
`define AATC_CTRL_TRIG_EDGE 4
`define AATC_CTRL_START 5
`define AATC_CTRL_STOP 6

// Mode, clock source and trigger source codes
`define AATC_MODE_ABOUT 1'b0
`define AATC_MODE_PRE 1'b1
`define AATC_CLK_INTERNAL 1'b0
`define AATC_CLK_EXTERNAL 1'b1
`define AATC_TRIG_SOFTWARE 2'h0
`define AATC_TRIG_DIGITAL 2'h1
`define AATC_TRIG_ANALOG 2'h2
`define AATC_EDGE_RISING 1'b0
`define AATC_EDGE_FALLING 1'b1

// Reset values
`define AATC_RST_CTRL 16'h0000
`define AATC_RST_DIVISOR 16'hffff
`define AATC_RST_PRE_COUNT 16'h0002
`define AATC_RST_TOTAL_COUNT 16'h0004
`define AATC_RST_THRESHOLD 8'h80

// Timing: system clock and time base, in MHz
`define AATC_SYS_CLK_MHZ 125
`define AATC_TIME_BASE_MHZ 10
// Fractional time base: add BASE each clock, wrap at SYS
`define AATC_TB_STEP 8'h0a
`define AATC_TB_MODULO 8'h7d
// Fastest internal rate in MS/s; smallest divisor follows from it
`define AATC_MAX_RATE_MSPS 2
`define AATC_DIV_MIN (`AATC_TIME_BASE_MHZ / `AATC_MAX_RATE_MSPS)

// Analog trigger: span in mV, hysteresis in mV, 12-bit trigger code
`define AATC_THR_SPAN_MV 20000
`define AATC_HYST_MV 50
`define AATC_HYST_LSB ((`AATC_HYST_MV * 4096) / `AATC_THR_SPAN_MV)

// Sample coding
`define AATC_CODE_MID 12'h800
`define AATC_CODE_TOP 12'hfff

`endif

// ===== hw/aatc_pacer.v
// Internal sample clock: 10 MHz time base and 16-bit divisor
// Assumes the 125 MHz system clock and a synchronised reset
`timescale 1ns/100ps
`default_nettype none
`include "aatc_map.vh"

module aatc_pacer #(
  parameter DIV_WIDTH = 16
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Control
  input wire run,
  input wire [DIV_WIDTH-1:0] divisor,
  // Counter output, high for one time-base tick per full count
  output reg pace_out
);

  localparam integer DIV_MIN_INT = `AATC_DIV_MIN;
  localparam [DIV_WIDTH-1:0] DIV_MIN = DIV_MIN_INT[DIV_WIDTH-1:0];

  reg [7:0] tb_acc;
  reg tb_tick;
  reg [DIV_WIDTH-1:0] count;
  wire [DIV_WIDTH-1:0] div_eff;
  wire [7:0] tb_sum;

  // Faster than the top rate cannot be honoured by the converter
  assign div_eff = (divisor < DIV_MIN) ? DIV_MIN : divisor;
  assign tb_sum = tb_acc + `AATC_TB_STEP;

  // 125 MHz does not divide to 10 MHz evenly; a phase accumulator keeps the mean
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tb_acc <= 8'h00;
      tb_tick <= 1'b0;
    end else if (tb_sum >= `AATC_TB_MODULO) begin
      tb_acc <= tb_sum - `AATC_TB_MODULO;
      tb_tick <= 1'b1;
    end else begin
      tb_acc <= tb_sum;
      tb_tick <= 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= {DIV_WIDTH{1'b0}};
      pace_out <= 1'b0;
    end else if (!run) begin
      count <= {DIV_WIDTH{1'b0}};
      pace_out <= 1'b0;
    end else if (tb_tick) begin
      if (count >= div_eff - 1'b1) begin
        count <= {DIV_WIDTH{1'b0}};
        pace_out <= 1'b1;
      end else begin
        count <= count + 1'b1;
        pace_out <= 1'b0;
      end
    end
  end

endmodule // aatc_pacer

`default_nettype wire

// ===== hw/aatc_trigger.v
// Trigger source select, analog comparator and edge detection
// Assumes inputs synchronous to the system clock
`timescale 1ns/100ps
`default_nettype none
`include "aatc_map.vh"

module aatc_trigger (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Selection
  input wire [1:0] trig_src,
  input wire trig_edge,
  // Sources
  input wire sw_trigger_flag,
  input wire ext_digital_trigger_in,
  input wire [11:0] analog_trigger_in,
  input wire [7:0] threshold_code,
  // One-cycle trigger event
  output reg trig_event
);

  localparam integer HYST_INT = `AATC_HYST_LSB;
  localparam [12:0] HYST = HYST_INT[12:0];

  reg cmp_above;
  reg src_prev;
  reg src_now;
  wire [12:0] thr_lo;
  wire [12:0] thr_hi;

  // Code 00 maps to the lowest level, ff to near the highest
  assign thr_lo = {1'b0, threshold_code, 4'h0};
  assign thr_hi = thr_lo + HYST;

  // Hysteresis stops a noisy input from firing repeatedly
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmp_above <= 1'b0;
    end else if ({1'b0, analog_trigger_in} >= thr_hi) begin
      cmp_above <= 1'b1;
    end else if ({1'b0, analog_trigger_in} < thr_lo) begin
      cmp_above <= 1'b0;
    end
  end

  always @* begin
    case (trig_src)
      `AATC_TRIG_SOFTWARE: src_now = sw_trigger_flag;
      `AATC_TRIG_DIGITAL: src_now = ext_digital_trigger_in;
      `AATC_TRIG_ANALOG: src_now = cmp_above;
      default: src_now = 1'b0;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_prev <= 1'b0;
      trig_event <= 1'b0;
    end else begin
      src_prev <= src_now;
      if (trig_edge == `AATC_EDGE_RISING) begin
        trig_event <= src_now & ~src_prev;
      end else begin
        trig_event <= ~src_now & src_prev;
      end
    end
  end

endmodule // aatc_trigger

`default_nettype wire

// ===== hw/aatc_acq_ctrl.v
// Analog-input acquisition and trigger control, top level
// Assumes an external converter and sample FIFO, and a plain register port
`timescale 1ns/100ps
`default_nettype none
`include "aatc_map.vh"

module aatc_acq_ctrl #(
  parameter DATA_WIDTH = 16,
  parameter SAMPLE_WIDTH = 12
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Register port
  input wire [2:0] reg_addr,
  input wire [DATA_WIDTH-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [DATA_WIDTH-1:0] reg_rdata,
  // Sample clock and trigger pins
  input wire ext_sample_clock_in,
  input wire ext_digital_trigger_in,
  input wire [11:0] analog_trigger_in,
  output reg [7:0] threshold_dac_code,
  // Converter
  output reg conv_start,
  input wire adc_valid,
  input wire [SAMPLE_WIDTH-1:0] adc_data,
  // Sample FIFO
  output reg fifo_wr_en,
  output reg [SAMPLE_WIDTH-1:0] fifo_wr_data,
  output reg fifo_drop_oldest,
  // Status
  output reg busy
);

  localparam ST_IDLE = 2'h0;
  localparam ST_PRE = 2'h1;
  localparam ST_POST = 2'h2;
  localparam ST_DONE = 2'h3;

  reg rst_meta;
  reg rst_sync;
  reg [1:0] state;
  reg [1:0] next_state;
  reg mode;
  reg clk_src;
  reg [1:0] trig_src;
  reg trig_edge;
  reg [15:0] divisor;
  reg [15:0] pre_count;
  reg [15:0] total_count;
  reg sw_trigger_flag;
  reg ext_clk_prev;
  reg pace_prev;
  reg [15:0] stored;
  reg [15:0] post_done;
  reg triggered;
  wire pace_out;
  wire trig_event;
  wire sample_edge;
  wire start_cmd;
  wire stop_cmd;
  wire [15:0] window;
  wire [15:0] post_target;
  wire acquiring;

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  function is_write;
    input [2:0] idx;
    begin
      is_write = reg_write && (reg_addr == idx);
    end
  endfunction

  assign start_cmd = is_write(`AATC_REG_CTRL) && reg_wdata[`AATC_CTRL_START];
  assign stop_cmd = is_write(`AATC_REG_CTRL) && reg_wdata[`AATC_CTRL_STOP];
  assign acquiring = (state == ST_PRE) || (state == ST_POST);

  aatc_pacer #(
    .DIV_WIDTH(16)
  ) u_pacer (
    .clock(clock),
    .rst_n(rst_sync),
    .run(acquiring && (clk_src == `AATC_CLK_INTERNAL)),
    .divisor(divisor),
    .pace_out(pace_out)
  );

  aatc_trigger u_trigger (
    .clock(clock),
    .rst_n(rst_sync),
    .trig_src(trig_src),
    .trig_edge(trig_edge),
    .sw_trigger_flag(sw_trigger_flag),
    .ext_digital_trigger_in(ext_digital_trigger_in),
    .analog_trigger_in(analog_trigger_in),
    .threshold_code(threshold_dac_code),
    .trig_event(trig_event)
  );

  // Register writes
  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      mode <= `AATC_MODE_ABOUT;
      clk_src <= `AATC_CLK_INTERNAL;
      trig_src <= `AATC_TRIG_SOFTWARE;
      trig_edge <= `AATC_EDGE_RISING;
      divisor <= `AATC_RST_DIVISOR;
      pre_count <= `AATC_RST_PRE_COUNT;
      total_count <= `AATC_RST_TOTAL_COUNT;
      threshold_dac_code <= `AATC_RST_THRESHOLD;
      sw_trigger_flag <= 1'b0;
    end else if (reg_write) begin
      case (reg_addr)
        `AATC_REG_CTRL: begin
          mode <= reg_wdata[`AATC_CTRL_MODE];
          clk_src <= reg_wdata[`AATC_CTRL_CLK_SRC];
          trig_src <= reg_wdata[`AATC_CTRL_TRIG_SRC_HI:`AATC_CTRL_TRIG_SRC_LO];
          trig_edge <= reg_wdata[`AATC_CTRL_TRIG_EDGE];
        end
        `AATC_REG_DIVISOR: divisor <= reg_wdata[15:0];
        `AATC_REG_PRE_COUNT: pre_count <= reg_wdata[15:0];
        `AATC_REG_TOTAL_COUNT: total_count <= reg_wdata[15:0];
        // Code spans the full -10 V to +10 V threshold range
        `AATC_REG_THRESHOLD: threshold_dac_code <= reg_wdata[7:0];
        `AATC_REG_SW_TRIGGER: sw_trigger_flag <= reg_wdata[0];
        default: sw_trigger_flag <= sw_trigger_flag;
      endcase
    end
  end

  // Read data stands one cycle after the read strobe only
  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata <= {DATA_WIDTH{1'b0}};
    end else if (reg_read) begin
      case (reg_addr)
        `AATC_REG_CTRL: reg_rdata <= {{(DATA_WIDTH-5){1'b0}}, trig_edge, trig_src, clk_src, mode};
        `AATC_REG_DIVISOR: reg_rdata <= divisor;
        `AATC_REG_PRE_COUNT: reg_rdata <= pre_count;
        `AATC_REG_TOTAL_COUNT: reg_rdata <= total_count;
        `AATC_REG_THRESHOLD: reg_rdata <= {{(DATA_WIDTH-8){1'b0}}, threshold_dac_code};
        `AATC_REG_STATUS: reg_rdata <= {{(DATA_WIDTH-4){1'b0}}, triggered, state, busy};
        `AATC_REG_SW_TRIGGER: reg_rdata <= {{(DATA_WIDTH-1){1'b0}}, sw_trigger_flag};
        `AATC_REG_STORED: reg_rdata <= stored;
        default: reg_rdata <= {DATA_WIDTH{1'b0}};
      endcase
    end else begin
      reg_rdata <= {DATA_WIDTH{1'b0}};
    end
  end

  // Sample clock: rising edge of the chosen source
  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      ext_clk_prev <= 1'b0;
      pace_prev <= 1'b0;
    end else begin
      ext_clk_prev <= ext_sample_clock_in;
      pace_prev <= pace_out;
    end
  end

  // External clock above the documented limit would outrun the converter
  assign sample_edge = (clk_src == `AATC_CLK_EXTERNAL) ?
                       (ext_sample_clock_in & ~ext_clk_prev) :
                       (pace_out & ~pace_prev);

  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= acquiring && sample_edge;
    end
  end

  // Pre-trigger keeps the last total; about-trigger keeps the last pre count
  assign window = (mode == `AATC_MODE_PRE) ? total_count : pre_count;
  assign post_target = total_count - pre_count;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_cmd) next_state = ST_PRE;
      ST_PRE: begin
        if (stop_cmd) begin
          next_state = ST_DONE;
        end else if (trig_event) begin
          next_state = (mode == `AATC_MODE_PRE) ? ST_DONE : ST_POST;
        end
      end
      ST_POST: begin
        if (stop_cmd) begin
          next_state = ST_DONE;
        end else if (adc_valid && (post_done + 1'b1 >= post_target)) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: if (start_cmd) next_state = ST_PRE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      triggered <= 1'b0;
      stored <= 16'h0000;
      post_done <= 16'h0000;
      fifo_wr_en <= 1'b0;
      fifo_wr_data <= {SAMPLE_WIDTH{1'b0}};
      fifo_drop_oldest <= 1'b0;
    end else begin
      state <= next_state;
      busy <= (next_state == ST_PRE) || (next_state == ST_POST);
      fifo_wr_en <= 1'b0;
      fifo_drop_oldest <= 1'b0;
      if ((state != ST_PRE) && (next_state == ST_PRE)) begin
        triggered <= 1'b0;
        stored <= 16'h0000;
        post_done <= 16'h0000;
      end else begin
        if (trig_event && (state == ST_PRE)) begin
          triggered <= 1'b1;
        end
        if (acquiring && adc_valid) begin
          // Straight binary code passes unchanged, 800h is mid-scale
          fifo_wr_en <= 1'b1;
          fifo_wr_data <= adc_data;
          if (state == ST_PRE) begin
            // Window full: oldest sample leaves as the new one enters
            if (stored >= window) begin
              fifo_drop_oldest <= 1'b1;
            end else begin
              stored <= stored + 1'b1;
            end
          end else begin
            stored <= stored + 1'b1;
            post_done <= post_done + 1'b1;
          end
        end
      end
    end
  end

endmodule // aatc_acq_ctrl

`default_nettype wire

// ===== testbench/aatc_acq_ctrl_chk.sv
// Port checker of the acquisition controller, bound to its top
// Assumes the register map header on the include path
`timescale 1ns/100ps
`default_nettype none
`include "aatc_map.vh"
module aatc_acq_ctrl_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  // Pins and converter
  input wire logic ext_sample_clock_in,
  input wire logic [7:0] threshold_dac_code,
  input wire logic conv_start,
  input wire logic adc_valid,
  input wire logic [11:0] adc_data,
  // FIFO and status
  input wire logic fifo_wr_en,
  input wire logic [11:0] fifo_wr_data,
  input wire logic fifo_drop_oldest,
  input wire logic busy
);
  // Shadow of control and flag, since the checker sees no registers
  reg [4:0] cfg;
  reg flag;
  wire wr0 = reg_write && reg_addr == `AATC_REG_CTRL;
  wire wr6 = reg_write && reg_addr == `AATC_REG_SW_TRIGGER;
  wire pre = cfg[`AATC_CTRL_MODE] == `AATC_MODE_PRE;
  wire [7:0] wlow = reg_wdata[7:0];
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= 5'h00;
      flag <= 1'b0;
    end else begin
      if (wr0) cfg <= reg_wdata[4:0];
      if (wr6) flag <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_word;
    fifo_wr_en |-> $past(adc_valid) && fifo_wr_data == $past(adc_data);
  endproperty
  a_word: assert property (p_word) else $error("stored word differs");
  property p_drop;
    fifo_drop_oldest |-> fifo_wr_en;
  endproperty
  a_drop: assert property (p_drop) else $error("drop without write");
  property p_space;
    conv_start |=> !conv_start [*8];
  endproperty
  a_space: assert property (p_space) else $error("conversions too close");
  property p_thr;
    reg_write && reg_addr == `AATC_REG_THRESHOLD |=> threshold_dac_code == $past(wlow);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold code not loaded");
  property p_start;
    wr0 && reg_wdata[`AATC_CTRL_START] && !busy |-> ##[1:2] busy;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_stop;
    wr0 && reg_wdata[`AATC_CTRL_STOP] && busy |-> ##[1:3] !busy;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_swtrg;
    wr6 && busy && pre && cfg[3:2] == `AATC_TRIG_SOFTWARE && reg_wdata[0] != flag
      && reg_wdata[0] != cfg[`AATC_CTRL_TRIG_EDGE] |-> ##[1:6] !busy;
  endproperty
  a_swtrg: assert property (p_swtrg) else $error("flag edge did not end capture");
  property p_ext;
    busy && cfg[`AATC_CTRL_CLK_SRC] && $rose(ext_sample_clock_in) |-> ##[1:3] conv_start;
  endproperty
  a_ext: assert property (p_ext) else $error("external edge not converted");
  c_drop: cover property (fifo_drop_oldest);
  c_end: cover property ($fell(busy));
  c_conv: cover property (conv_start);
endmodule // aatc_acq_ctrl_chk
bind aatc_acq_ctrl aatc_acq_ctrl_chk u_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .ext_sample_clock_in(ext_sample_clock_in),
  .threshold_dac_code(threshold_dac_code), .conv_start(conv_start), .adc_valid(adc_valid),
  .adc_data(adc_data), .fifo_wr_en(fifo_wr_en), .fifo_wr_data(fifo_wr_data),
  .fifo_drop_oldest(fifo_drop_oldest), .busy(busy));
`default_nettype wire

// ===== testbench/aatc_adc_model.sv
// Converter and sample FIFO stand-in on the far side of the controller
// Assumes conversion requests far apart, as the pacing limits give
`timescale 1ns/100ps
`default_nettype none
module aatc_adc_model (
  // Clock
  input wire logic clock,
  // Converter
  input wire logic conv_start,
  input wire logic slow,
  input wire logic [11:0] code_in,
  output logic adc_valid,
  output logic [11:0] adc_data,
  // FIFO
  input wire logic level_clr,
  input wire logic fifo_wr_en,
  input wire logic fifo_drop_oldest,
  output logic [15:0] fifo_level
);
  logic [2:0] wait_n = 3'h0;
  logic [11:0] held = 12'h000;
  initial adc_valid = 1'b0;
  initial adc_data = 12'h000;
  initial fifo_level = 16'h0000;
  always @(posedge clock) begin
    adc_valid <= 1'b0;
    // Word changes every cycle so a late capture cannot match by luck
    adc_data <= ~adc_data;
    if (conv_start) begin
      held <= code_in;
      wait_n <= slow ? 3'h4 : 3'h1;
    end else if (wait_n != 3'h0) begin
      wait_n <= wait_n - 3'h1;
      if (wait_n == 3'h1) begin
        adc_valid <= 1'b1;
        adc_data <= held;
      end
    end
    if (level_clr) fifo_level <= 16'h0000;
    else if (fifo_wr_en && !fifo_drop_oldest) fifo_level <= fifo_level + 16'h0001;
  end
endmodule // aatc_adc_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench of the acquisition controller
// Assumes the converter and FIFO stand-in and the register map header
`timescale 1ns/100ps
`default_nettype none
`include "aatc_map.vh"
`define CMP(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h %h", $time, g, e); end end
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_d = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_en = 1'b0;
  logic ext_trg = 1'b1;
  logic clr = 1'b0;
  logic [11:0] ana = 12'h000;
  logic [7:0] thr;
  logic [31:0] lfsr = 32'hd9ea2c22;
  logic [15:0] ev;
  logic [11:0] se;
  logic [15:0] rq[$];
  logic [11:0] sq[$];
  logic [15:0] rst_tab[8] = '{`AATC_RST_CTRL, `AATC_RST_DIVISOR, `AATC_RST_PRE_COUNT,
    `AATC_RST_TOTAL_COUNT, {8'h00, `AATC_RST_THRESHOLD}, 16'h0000, 16'h0000, 16'h0000};
  int dv[2] = '{5, 40};
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  int k;
  int t;
  wire logic [15:0] rdata, level;
  wire logic [7:0] dac;
  wire logic conv, valid, fwr, fdrop, busy;
  wire logic [11:0] adata, fdata;
  aatc_acq_ctrl dut (.clock(clock), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .ext_sample_clock_in(ext_clk),
    .ext_digital_trigger_in(ext_trg), .analog_trigger_in(ana), .threshold_dac_code(dac),
    .conv_start(conv), .adc_valid(valid), .adc_data(adata), .fifo_wr_en(fwr),
    .fifo_wr_data(fdata), .fifo_drop_oldest(fdrop), .busy(busy));
  aatc_adc_model u_adc (.clock(clock), .conv_start(conv), .slow(lfsr[20]),
    .code_in(lfsr[11:0]), .adc_valid(valid), .adc_data(adata), .level_clr(clr),
    .fifo_wr_en(fwr), .fifo_drop_oldest(fdrop), .fifo_level(level));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Gap cycle after each strobe keeps one assignment per time step
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    if (w) wr_s <= 1'b1;
    else begin
      rd_s <= 1'b1;
      rq.push_back(d);
    end
    @(posedge clock);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clock);
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (conv !== 1'b1 && n < 9000);
  endtask
  task automatic wait_busy(input logic v);
    for (t = 0; t < 3000 && busy !== v; t++) @(posedge clock);
    `CMP(busy, v)
  endtask
  task automatic clear;
    sq.delete();
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask
  always #4 clock = ~clock;
  always @(posedge clock) begin
    lfsr <= nxt(lfsr);
    cyc++;
    if (cyc % 40 == 0) ext_clk <= ext_en & ~ext_clk;
    rd_d <= rd_s;
    if (rd_d) begin
      ev = rq.pop_front();
      `CMP(rdata, ev)
    end
    if (fwr) begin
      se = sq.pop_front();
      `CMP(fdata, se)
    end
    if (valid && busy) sq.push_back(adata);
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    `CMP(dac, 8'h80)
    for (i = 0; i < 8; i++) bus(0, i[2:0], rst_tab[i]);
    bus(1, `AATC_REG_STATUS, 16'hffff);
    bus(0, `AATC_REG_STATUS, 16'h0000);
    $display("reset values done");
    foreach (dv[k]) begin
      bus(1, `AATC_REG_DIVISOR, dv[k][15:0]);
      bus(1, `AATC_REG_CTRL, 16'h002c);
      gap(t);
      gap(t);
      `CMP(t * 2 >= dv[k] * 25 - 2 && t * 2 <= dv[k] * 25 + 2, 1'b1)
      bus(1, `AATC_REG_CTRL, 16'h0040);
      wait_busy(1'b0);
    end
    $display("pacing done");
    clear;
    bus(1, `AATC_REG_DIVISOR, 16'd5);
    bus(1, `AATC_REG_TOTAL_COUNT, 16'd5);
    bus(1, `AATC_REG_SW_TRIGGER, 16'h0000);
    bus(1, `AATC_REG_CTRL, 16'h0021);
    repeat (8) gap(t);
    `CMP(busy, 1'b1)
    bus(1, `AATC_REG_SW_TRIGGER, 16'h0001);
    wait_busy(1'b0);
    `CMP(level, 16'd5)
    bus(0, `AATC_REG_STORED, 16'd5);
    $display("pre-trigger done");
    clear;
    bus(1, `AATC_REG_PRE_COUNT, 16'd2);
    bus(1, `AATC_REG_TOTAL_COUNT, 16'd6);
    ext_en <= 1'b1;
    bus(1, `AATC_REG_CTRL, 16'h0036);
    repeat (4) gap(t);
    `CMP(level, 16'd2)
    ext_trg <= 1'b0;
    wait_busy(1'b0);
    bus(0, `AATC_REG_STORED, 16'd6);
    `CMP(level, 16'd6)
    ext_en <= 1'b0;
    ext_trg <= 1'b1;
    $display("about-trigger done");
    // Falling software edge, then stop while collecting after the trigger
    bus(1, `AATC_REG_CTRL, 16'h0030);
    repeat (3) gap(t);
    bus(1, `AATC_REG_SW_TRIGGER, 16'h0000);
    @(posedge clock);
    `CMP(busy, 1'b1)
    bus(1, `AATC_REG_CTRL, 16'h0040);
    wait_busy(1'b0);
    bus(0, `AATC_REG_STATUS, 16'h000e);
    $display("falling software trigger done");
    for (i = 0; i < 2; i++) begin
      clear;
      thr = 8'h08 + lfsr[7:0] % 8'he0;
      bus(1, `AATC_REG_THRESHOLD, {8'h00, thr});
      `CMP(dac, thr)
      ana <= i ? {thr, 4'h0} + 12'd30 : {thr, 4'h0} - 12'd20;
      bus(1, `AATC_REG_CTRL, i ? 16'h0039 : 16'h0029);
      repeat (3) gap(t);
      ana <= {thr, 4'h0} + 12'd5;
      repeat (2) gap(t);
      `CMP(busy, 1'b1)
      ana <= i ? {thr, 4'h0} - 12'd20 : {thr, 4'h0} + 12'd30;
      wait_busy(1'b0);
    end
    $display("analog trigger done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
